// *** src/meas_loop_pkg.sv ***
package meas_loop_pkg;

    // ==========================================
    // Register map
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_BLOCK_SIZE = 8'h08;
    localparam logic [7:0] OFS_LO_PENDING = 8'h0C;
    localparam logic [7:0] OFS_LO_ACTIVE = 8'h10;

    // ==========================================
    // Control register fields
    localparam int CTL_IDLE = 0;
    localparam int CTL_SYNC = 1;
    localparam int CTL_CONT = 2;
    localparam int CTL_FIRST_FRAME = 3;
    localparam int CTL_NORMAL = 4;
    localparam int CTL_W = 5;
    localparam logic [CTL_W-1:0] CTL_RESET = 5'h08;

    // ==========================================
    // Status word fields
    localparam int STAT_W = 16;
    localparam int ST_PASSED = 2;
    localparam int ST_READY = 3;
    localparam int ST_ADC_ERR = 4;
    localparam int ST_CLK_FAST = 5;
    localparam int ST_SETUP_ERR = 6;
    localparam int ST_SYNC_DONE = 7;
    localparam int ST_READ_VALID = 8;
    localparam int ST_MEAS_DONE = 9;
    localparam int ST_ARMED = 10;
    localparam int ST_OVERFLOW = 11;
    localparam int ST_OVERLOAD = 12;
    localparam logic [1:0] CODE_IDLE = 2'h0;
    localparam logic [1:0] CODE_ARM = 2'h1;
    localparam logic [1:0] CODE_MEAS = 2'h2;
    localparam logic [1:0] CODE_TRIG = 2'h3;

    // ==========================================
    // Sticky flag slots
    localparam int NFLAG = 6;
    localparam int F_ADC = 0;
    localparam int F_CLK = 1;
    localparam int F_SETUP = 2;
    localparam int F_SYNC = 3;
    localparam int F_OVF = 4;
    localparam int F_OVL = 5;

    // ==========================================
    // Block size, LO and timing
    localparam int BLK_W = 16;
    localparam logic [BLK_W-1:0] BLK_MIN = 16'h0001;
    localparam logic [BLK_W-1:0] BLK_RESET = 16'h0400;
    localparam int LO_W = 32;
    localparam int FIFO_WORDS = 4194304;
    localparam int CLK_PERIOD_NS = 50;
    localparam int SYNC_HOLD_NS = 400;
    localparam int SYNC_HOLD_CYCLES = (SYNC_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {S_IDLE, S_ARM, S_TRIG, S_MEAS} loop_state_e;

    typedef struct packed {
        logic sample_valid;
        logic word_read;
        logic trigger;
        logic pretrig_ok;
        logic hw_fault;
        logic over_range;
        logic clk_too_fast;
    } conv_event_s;

endpackage

// *** src/sticky_flags.sv ***
`timescale 1ns/1ps
module sticky_flags
    import meas_loop_pkg::*;
#(
    parameter int N = NFLAG
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Events and clears
    input wire logic [N-1:0] set,
    input wire logic [N-1:0] clr,
    // Flags
    output logic [N-1:0] flags_q
);

    // ==========================================
    // One flag per bit, set wins over clear
    for (genvar i = 0; i < N; i++)
    begin : g_flag
        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
                flags_q[i] <= 1'b0;
            else if (set[i])
                flags_q[i] <= 1'b1;
            else if (clr[i])
                flags_q[i] <= 1'b0;
        end
    end

endmodule

// *** src/sync_line_port.sv ***
`timescale 1ns/1ps
module sync_line_port
    import meas_loop_pkg::*;
#(
    parameter int HOLD_CYCLES = SYNC_HOLD_CYCLES
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Request from the loop
    input wire logic drive_req,
    // Open-drain sync pin, active low
    input wire logic sync_n_i,
    output logic sync_n_o,
    output logic sync_n_oe,
    // Line view
    output logic line_act_q,
    output logic assert_edge,
    output logic release_edge,
    output logic hold_busy
);

    logic [$clog2(HOLD_CYCLES+1)-1:0] hold_q;
    logic prev_q;

    assign sync_n_o = 1'b0;

    // ==========================================
    // Driver with minimum hold
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync_n_oe <= 1'b0;
            hold_q <= '0;
        end
        else
        begin
            if (drive_req && !sync_n_oe)
                hold_q <= ($clog2(HOLD_CYCLES+1))'(HOLD_CYCLES - 1);
            else if (hold_q != '0)
                hold_q <= hold_q - 1'b1;
            sync_n_oe <= drive_req || (sync_n_oe && hold_q != '0);
        end
    end

    assign hold_busy = sync_n_oe && (hold_q != '0);

    // ==========================================
    // Wired line sampling
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            line_act_q <= 1'b0;
            prev_q <= 1'b0;
        end
        else
        begin
            line_act_q <= !sync_n_i;
            prev_q <= line_act_q;
        end
    end

    assign assert_edge = line_act_q && !prev_q;
    assign release_edge = !line_act_q && prev_q;

    // ==========================================
    // Checks
    a_hold_min: assert property (@(posedge clk) disable iff (!rst_n) $rose(sync_n_oe) |-> sync_n_oe [*8])
        else $error("sync drive shorter than hold time");

endmodule

// *** src/meas_loop.sv ***
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module meas_loop
    import meas_loop_pkg::*;
#(
    parameter int FIFO_DEPTH = FIFO_WORDS,
    parameter int HOLD_CYCLES = SYNC_HOLD_CYCLES
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Converter and data path events
    input wire conv_event_s conv_ev,
    // Shared sync pin
    input wire logic sync_n_i,
    output logic sync_n_o,
    output logic sync_n_oe,
    // Loop outputs
    output logic [LO_W-1:0] lo_freq,
    output logic collecting
);

    localparam int CNT_W = $clog2(FIFO_DEPTH + 1);

    loop_state_e state_q, state_d;
    logic [CTL_W-1:0] ctl_q;
    logic [BLK_W-1:0] blk_q;
    logic [LO_W-1:0] lo_pend_q;
    logic [CNT_W-1:0] fifo_q;
    logic [BLK_W-1:0] samp_q;
    logic pend_q;
    logic [NFLAG-1:0] flags_q, flag_set, flag_clr;
    logic [STAT_W-1:0] stat_w;
    logic [1:0] code_w;
    logic line_act, assert_edge, release_edge, hold_busy;
    logic drive_req, armed_w, blk_done, fifo_full, accept, ovf_ev, lo_load;
    logic host_drv, cont, force_idle;
    logic setup_ph, wr_acc, rd_stat, ctl_chg, blk_bad;

    // ==========================================
    // APB decode
    assign setup_ph = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    assign rd_stat = psel && penable && !pwrite && paddr == OFS_STATUS;
    assign pready = 1'b1;
    assign ctl_chg = wr_acc && paddr == OFS_CONTROL
        && (pwdata[CTL_IDLE] != ctl_q[CTL_IDLE] || pwdata[CTL_SYNC] != ctl_q[CTL_SYNC]);
    assign blk_bad = pwdata[BLK_W-1:0] == '0;

    assign cont = ctl_q[CTL_CONT];
    assign force_idle = ctl_q[CTL_IDLE];
    assign host_drv = ctl_q[CTL_SYNC] && ctl_q[CTL_FIRST_FRAME];

    // ==========================================
    // Register writes
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctl_q <= CTL_RESET;
            blk_q <= BLK_RESET;
            lo_pend_q <= '0;
        end
        else if (wr_acc)
        begin
            case (paddr)
                OFS_CONTROL: ctl_q <= pwdata[CTL_W-1:0];
                OFS_BLOCK_SIZE: blk_q <= blk_bad ? BLK_MIN : pwdata[BLK_W-1:0];
                OFS_LO_PENDING: lo_pend_q <= pwdata[LO_W-1:0];
                default: ;
            endcase
        end
    end

    // ==========================================
    // Read data, registered in the setup phase
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata <= '0;
            pslverr <= 1'b0;
        end
        else if (setup_ph)
        begin
            pslverr <= 1'b0;
            case (paddr)
                OFS_CONTROL: prdata <= 32'(ctl_q);
                OFS_STATUS: prdata <= 32'(stat_w);
                OFS_BLOCK_SIZE: prdata <= 32'(blk_q);
                OFS_LO_PENDING: prdata <= 32'(lo_pend_q);
                OFS_LO_ACTIVE: prdata <= 32'(lo_freq);
                default:
                begin
                    prdata <= '0;
                    pslverr <= 1'b1;
                end
            endcase
        end
    end

    // ==========================================
    // Sync line port
    sync_line_port #(
        .HOLD_CYCLES(HOLD_CYCLES)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .drive_req(drive_req),
        .sync_n_i(sync_n_i),
        .sync_n_o(sync_n_o),
        .sync_n_oe(sync_n_oe),
        .line_act_q(line_act),
        .assert_edge(assert_edge),
        .release_edge(release_edge),
        .hold_busy(hold_busy)
    );

    // ==========================================
    // Measurement loop
    assign armed_w = state_q == S_TRIG || (state_q == S_ARM && conv_ev.pretrig_ok);
    assign blk_done = samp_q >= blk_q;

    always_comb
    begin
        drive_req = host_drv;
        case (state_q)
            S_ARM: drive_req = !armed_w || host_drv;
            S_MEAS:
            begin
                if (cont)
                    drive_req = host_drv;
                else
                    drive_req = !blk_done;
            end
            default: drive_req = host_drv;
        endcase
    end

    always_comb
    begin
        state_d = state_q;
        if (force_idle)
            state_d = S_IDLE;
        else
        begin
            case (state_q)
                S_IDLE: if (assert_edge) state_d = S_ARM;
                S_ARM: if (armed_w && !line_act) state_d = S_TRIG;
                S_TRIG: if (conv_ev.trigger || assert_edge) state_d = S_MEAS;
                S_MEAS:
                begin
                    if (cont && ovf_ev)
                        state_d = S_IDLE;
                    else if (!cont && blk_done && release_edge)
                        state_d = S_IDLE;
                end
                default: state_d = S_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            state_q <= S_IDLE;
        else
            state_q <= state_d;
    end

    assign collecting = state_q == S_MEAS;

    // ==========================================
    // Local oscillator load
    assign lo_load = assert_edge && !force_idle
        && (state_q == S_IDLE || (state_q == S_MEAS && cont));

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            lo_freq <= '0;
        else if (lo_load)
            lo_freq <= lo_pend_q;
    end

    // ==========================================
    // FIFO fill and block sample count
    assign fifo_full = fifo_q == CNT_W'(FIFO_DEPTH);
    assign accept = collecting && conv_ev.sample_valid && (cont || !blk_done) && !fifo_full;
    assign ovf_ev = collecting && cont && conv_ev.sample_valid && fifo_full && !conv_ev.word_read;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            fifo_q <= '0;
        else
        begin
            case ({accept, conv_ev.word_read && fifo_q != '0})
                2'b10: fifo_q <= fifo_q + 1'b1;
                2'b01: fifo_q <= fifo_q - 1'b1;
                default: fifo_q <= fifo_q;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            samp_q <= '0;
        else if (state_q == S_TRIG)
            samp_q <= '0;
        else if (accept && !blk_done)
            samp_q <= samp_q + 1'b1;
    end

    // ==========================================
    // Host change propagation
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pend_q <= 1'b0;
        else if (ctl_chg)
            pend_q <= 1'b1;
        else if (flag_set[F_SYNC])
            pend_q <= 1'b0;
    end

    // ==========================================
    // Sticky status flags
    always_comb
    begin
        flag_set = '0;
        flag_clr = '0;
        flag_set[F_ADC] = conv_ev.hw_fault;
        flag_set[F_CLK] = conv_ev.clk_too_fast;
        flag_set[F_SETUP] = wr_acc && paddr == OFS_BLOCK_SIZE && blk_bad;
        flag_set[F_SYNC] = pend_q && !hold_busy && (!force_idle || state_q == S_IDLE);
        flag_set[F_OVF] = ovf_ev;
        flag_set[F_OVL] = conv_ev.over_range;
        flag_clr[F_ADC] = rd_stat && prdata[ST_ADC_ERR];
        flag_clr[F_CLK] = rd_stat && prdata[ST_CLK_FAST];
        flag_clr[F_SETUP] = rd_stat && prdata[ST_SETUP_ERR];
        flag_clr[F_SYNC] = ctl_chg;
        flag_clr[F_OVF] = ctl_chg && pwdata[CTL_IDLE];
        flag_clr[F_OVL] = rd_stat && prdata[ST_OVERLOAD];
    end

    sticky_flags #(
        .N(NFLAG)
    ) u_flags (
        .clk(clk),
        .rst_n(rst_n),
        .set(flag_set),
        .clr(flag_clr),
        .flags_q(flags_q)
    );

    // ==========================================
    // Status word
    always_comb
    begin
        case (state_q)
            S_ARM: code_w = CODE_ARM;
            S_TRIG: code_w = CODE_TRIG;
            S_MEAS: code_w = CODE_MEAS;
            default: code_w = CODE_IDLE;
        endcase
    end

    always_comb
    begin
        stat_w = '0;
        stat_w[1:0] = code_w;
        stat_w[ST_PASSED] = 1'b1;
        stat_w[ST_READY] = ctl_q[CTL_NORMAL];
        stat_w[ST_ADC_ERR] = flags_q[F_ADC];
        stat_w[ST_CLK_FAST] = flags_q[F_CLK];
        stat_w[ST_SETUP_ERR] = flags_q[F_SETUP];
        stat_w[ST_SYNC_DONE] = flags_q[F_SYNC];
        stat_w[ST_READ_VALID] = fifo_q != '0;
        stat_w[ST_MEAS_DONE] = cont ? 32'(fifo_q) >= 32'(blk_q) : blk_done;
        stat_w[ST_ARMED] = armed_w;
        stat_w[ST_OVERFLOW] = flags_q[F_OVF];
        stat_w[ST_OVERLOAD] = flags_q[F_OVL];
    end

    // ==========================================
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_state_code: assert property (psel && !penable && paddr == OFS_STATUS ##1 1'b1 |->
            prdata[1:0] == (($past(state_q) == S_MEAS) ? CODE_MEAS : ($past(state_q) == S_IDLE) ? CODE_IDLE
            : ($past(state_q) == S_ARM) ? CODE_ARM : CODE_TRIG))
        else $error("status state code mismatch");

    a_passed_one: assert property (rd_stat && !pslverr |-> prdata[ST_PASSED])
        else $error("passed bit not one");

    a_block_hold: assert property (state_q == S_MEAS && !cont && !blk_done |=> sync_n_oe)
        else $error("block measure released sync early");

    a_block_idle: assert property (state_q == S_MEAS && !cont && blk_done && release_edge && !force_idle
            |=> state_q == S_IDLE)
        else $error("block mode did not go idle on release");

    a_cont_release: assert property (state_q == S_TRIG && state_d == S_MEAS && cont && !host_drv
            |=> !drive_req)
        else $error("continuous measure still drives sync");

    a_cont_stay: assert property (state_q == S_MEAS && cont && !force_idle && !ovf_ev
            |=> state_q == S_MEAS)
        else $error("continuous measure left without cause");

    a_idle_arm: assert property (state_q == S_IDLE && assert_edge && !force_idle
            |=> state_q == S_ARM && lo_freq == $past(lo_pend_q))
        else $error("idle sync pulse did not arm");

    a_cont_lo: assert property (state_q == S_MEAS && cont && assert_edge && !force_idle && !ovf_ev
            |=> state_q == S_MEAS && lo_freq == $past(lo_pend_q))
        else $error("continuous LO update failed");

    a_fault_clear: assert property (rd_stat && prdata[ST_ADC_ERR] && !conv_ev.hw_fault
            |=> !flags_q[F_ADC])
        else $error("fault flag not cleared by read");

    a_overflow_set: assert property (ovf_ev |=> flags_q[F_OVF] && state_q == S_IDLE)
        else $error("overflow not flagged");

    a_armed_trig: assert property (state_q == S_ARM && conv_ev.pretrig_ok && !line_act && !force_idle
            |=> state_q == S_TRIG)
        else $error("armed module did not trigger");

endmodule

// *** bench/peer_sync_model.sv ***
`timescale 1ns/1ps
// ==========================================
// Peer module sharing the sync line
module peer_sync_model #(
    parameter int HOLD = 8
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Commands from the bench
    input wire logic pulse,
    input wire logic stretch,
    // Open-drain pull, high while pulling low
    output logic pull_oe
);
    logic [7:0] cnt_q;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_q <= 8'h00;
        else if (pulse)
            cnt_q <= 8'(HOLD);
        else if (cnt_q != 8'h00)
            cnt_q <= cnt_q - 8'h01;
    end
    assign pull_oe = (cnt_q != 8'h00) || stretch;
endmodule

// *** bench/tb_meas_loop.sv ***
`timescale 1ns/1ps
module tb_meas_loop;
    import meas_loop_pkg::*;
    // ==========================================
    // Signals and instances
    localparam int DEPTH = 16;
    localparam logic [6:0] M_SV = 7'h40, M_WR = 7'h20, M_TRG = 7'h10;
    localparam logic [6:0] M_FLT = 7'h04, M_OVR = 7'h02, M_CLK = 7'h01;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, err, sync_n_o, sync_n_oe, collecting;
    logic [LO_W-1:0] lo_freq;
    conv_event_s ev = '0;
    logic peer_pulse = 1'b0, peer_stretch = 1'b0, peer_oe;
    logic sync_line_n;
    int fail_count = 0;
    int cmp_count = 0;
    // Pull-up on the wired line
    assign sync_line_n = (sync_n_oe ? sync_n_o : 1'b1) & ~peer_oe;
    always #25 clk = ~clk;
    meas_loop #(.FIFO_DEPTH(DEPTH), .HOLD_CYCLES(8)) i_dut (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .conv_ev(ev), .sync_n_i(sync_line_n), .sync_n_o(sync_n_o),
        .sync_n_oe(sync_n_oe), .lo_freq(lo_freq), .collecting(collecting));
    peer_sync_model #(.HOLD(8)) i_peer (.clk(clk), .rst_n(rst_n), .pulse(peer_pulse),
        .stretch(peer_stretch), .pull_oe(peer_oe));
    // ==========================================
    // Tasks
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
            if (n > 20)
            begin
                fail_count++;
                give_verdict();
            end
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd & m, exp);
    endtask
    task automatic wait_st(input logic [1:0] code);
        int n;
        for (n = 0; n < 100; n++)
        begin
            apb(1'b0, OFS_STATUS, 32'h0);
            if (rd[1:0] === code)
                return;
        end
        fail_count++;
        give_verdict();
    endtask
    task automatic pulse(input logic [6:0] m);
        ev <= conv_event_s'(ev | m);
        @(posedge clk);
        ev <= conv_event_s'(ev & ~m);
        @(posedge clk);
    endtask
    // ==========================================
    // Test sequence
    initial
    begin
        logic [6:0] fm[3];
        logic [31:0] fb[3];
        int n;
        fm = '{M_FLT, M_CLK, M_OVR};
        fb = '{32'h10, 32'h20, 32'h1000};
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rdm(OFS_CONTROL, 32'hFFFFFFFF, 32'h8);
        rdm(OFS_STATUS, 32'hF, 32'h4);
        apb(1'b1, OFS_CONTROL, 32'h18);
        rdm(OFS_STATUS, 32'h8, 32'h8);
        apb(1'b1, OFS_BLOCK_SIZE, 32'h0);
        rdm(OFS_STATUS, 32'h40, 32'h40);
        rdm(OFS_STATUS, 32'h40, 32'h0);
        rdm(OFS_BLOCK_SIZE, 32'hFFFF, 32'h1);
        apb(1'b0, 8'hF0, 32'h0);
        check({rd[30:0], err}, 32'h1);
        for (n = 0; n < 3; n++)
        begin
            pulse(fm[n]);
            rdm(OFS_STATUS, fb[n], fb[n]);
            rdm(OFS_STATUS, fb[n], 32'h0);
        end
        // Block mode measurement with a slow peer
        apb(1'b1, OFS_BLOCK_SIZE, 32'h4);
        apb(1'b1, OFS_LO_PENDING, 32'h12345678);
        apb(1'b1, OFS_CONTROL, 32'h19);
        apb(1'b1, OFS_CONTROL, 32'h18);
        rdm(OFS_STATUS, 32'h80, 32'h80);
        apb(1'b1, OFS_CONTROL, 32'h1A);
        wait_st(CODE_ARM);
        check(lo_freq, 32'h12345678);
        check(sync_n_oe, 1'b1);
        apb(1'b1, OFS_CONTROL, 32'h18);
        ev.pretrig_ok <= 1'b1;
        wait_st(CODE_TRIG);
        rdm(OFS_STATUS, 32'h483, 32'h483);
        pulse(M_TRG);
        wait_st(CODE_MEAS);
        check(collecting, 1'b1);
        check(sync_n_oe, 1'b1);
        apb(1'b1, OFS_CONTROL, 32'h1A);
        apb(1'b1, OFS_CONTROL, 32'h18);
        rdm(OFS_STATUS, 32'h3, 32'h2);
        peer_stretch <= 1'b1;
        repeat (4) pulse(M_SV);
        for (n = 0; n < 200 && sync_n_oe !== 1'b0; n++)
            @(posedge clk);
        if (n == 200)
        begin
            fail_count++;
            give_verdict();
        end
        rdm(OFS_STATUS, 32'h303, 32'h302);
        peer_stretch <= 1'b0;
        wait_st(CODE_IDLE);
        check(collecting, 1'b0);
        ev.pretrig_ok <= 1'b0;
        repeat (4) pulse(M_WR);
        rdm(OFS_STATUS, 32'h100, 32'h0);
        // Continuous mode measurement
        apb(1'b1, OFS_LO_PENDING, 32'h0000ABCD);
        apb(1'b1, OFS_CONTROL, 32'h1E);
        apb(1'b1, OFS_CONTROL, 32'h1C);
        ev.pretrig_ok <= 1'b1;
        wait_st(CODE_TRIG);
        pulse(M_TRG);
        wait_st(CODE_MEAS);
        check(sync_n_oe, 1'b0);
        apb(1'b1, OFS_LO_PENDING, 32'h5555AAAA);
        peer_pulse <= 1'b1;
        @(posedge clk);
        peer_pulse <= 1'b0;
        repeat (12) @(posedge clk);
        check(lo_freq, 32'h5555AAAA);
        rdm(OFS_STATUS, 32'h203, 32'h2);
        repeat (4) pulse(M_SV);
        rdm(OFS_STATUS, 32'h200, 32'h200);
        repeat (DEPTH - 4) pulse(M_SV);
        rdm(OFS_STATUS, 32'h803, 32'h2);
        pulse(M_SV);
        wait_st(CODE_IDLE);
        rdm(OFS_STATUS, 32'h803, 32'h800);
        apb(1'b1, OFS_CONTROL, 32'h1D);
        rdm(OFS_STATUS, 32'h800, 32'h0);
        // Sync request outside the first frame
        ev.pretrig_ok <= 1'b0;
        apb(1'b1, OFS_CONTROL, 32'h16);
        repeat (10) @(posedge clk);
        check(sync_n_oe, 1'b0);
        rdm(OFS_STATUS, 32'h3, 32'h0);
        give_verdict();
    end
endmodule
